/* File: rtl/event_flags_pkg.sv */
// Constants for the peripheral event flag block: bit positions, register
// offsets, field layouts, mode codes and reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Overview of operation
// - Serial transfer done sets serial flag, bit 3.
// - Serial flag holds until software clears it.
// - Finished requested start sets serial flag.
// - Finished requested stop sets serial flag.
// - Finished requested repeated start sets serial flag.
// - Finished requested acknowledge sets serial flag.
// - Bus start seen while idle sets flag.
// - Bus stop seen while idle sets flag.
// - Capture event sets capture/compare flag, bit 2.
// - Compare equality sets capture/compare flag, sticky.
// - Timer8 period match sets bit 1, sticky.
// - Timer16 rollover sets bit 0, sticky.
// - Flags set regardless of any enable.
// - Unimplemented flag register bits read zero.
// - All flags clear to zero at reset.
package event_flags_pkg;

  localparam int FLAG_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = DATA_W / 8;
  localparam int LANE_W = 8;

  // Flag positions in the flag register.
  localparam int OVF_BIT = 0;
  localparam int PERIOD_BIT = 1;
  localparam int CCP_BIT = 2;
  localparam int SERIAL_BIT = 3;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CMP_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FORCE_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] CAP_OFS = 8'h14;

  // Capture/compare mode field, bits 1:0 of the mode register.
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
  localparam logic [MODE_W-1:0] MODE_CAPTURE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_COMPARE = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PWM = 2'h3;

  // Reset values.
  localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
  localparam logic [FLAG_W-1:0] MASK_RST = 4'h0;
  localparam logic [MODE_W-1:0] MODE_RST = MODE_OFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage : event_flags_pkg

/* File: rtl/sticky_flag_bank.sv */
// Bank of sticky flags: a set input per bit and a clear input per bit.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/100ps

module sticky_flag_bank #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flags_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("sticky_flag_bank: WIDTH must be at least one");
    end
    // The reset word is only as wide as the flag register.
    if (WIDTH > event_flags_pkg::FLAG_W) begin
      $error("sticky_flag_bank: WIDTH wider than the flag register");
    end
  end

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < WIDTH; i++) begin
      // A set in the same cycle as a clear leaves the flag set.
      if (set_i[i]) begin
        st_nxt.flags[i] = 1'b1;
      end else if (clr_i[i]) begin
        st_nxt.flags[i] = 1'b0;
      end else begin
        st_nxt.flags[i] = st_r.flags[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.flags <= event_flags_pkg::FLAGS_RST[WIDTH-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_o = st_r.flags;

endmodule : sticky_flag_bank

/* File: rtl/peripheral_event_flags_low.sv */
// Peripheral event flag register, lower half: four sticky flags set by the
// serial module, the capture/compare unit and the two timers, a mask
// register and one level interrupt output, all behind a Wishbone slave.
// Assumes every event input comes from logic on clk_i, so no input is
// synchronised; event strobes are one-cycle pulses.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module peripheral_event_flags_low #(
  parameter int T16_W = 16,
  parameter int T8_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [event_flags_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [event_flags_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [event_flags_pkg::DATA_W-1:0] wb_dat_i,
  output logic [event_flags_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Synchronous serial module events.
  input wire logic serial_xfer_done_i,
  input wire logic i2c_master_mode_i,
  input wire logic i2c_start_done_i,
  input wire logic i2c_stop_done_i,
  input wire logic i2c_restart_done_i,
  input wire logic i2c_ack_done_i,
  input wire logic serial_idle_i,
  input wire logic bus_start_seen_i,
  input wire logic bus_stop_seen_i,
  // Capture/compare unit and timers.
  input wire logic capture_strobe_i,
  input wire logic [T16_W-1:0] timer16_count_i,
  input wire logic [T8_W-1:0] timer8_count_i,
  input wire logic [T8_W-1:0] timer8_period_i,
  // Flag view and interrupt.
  output logic [event_flags_pkg::FLAG_W-1:0] flags_o,
  output logic irq_o
);

  localparam int FW = event_flags_pkg::FLAG_W;
  localparam int DW = event_flags_pkg::DATA_W;
  localparam int MW = event_flags_pkg::MODE_W;
  localparam logic [T16_W-1:0] T16_MAX = {T16_W{1'b1}};
  localparam logic [T16_W-1:0] T16_ZERO = {T16_W{1'b0}};
  localparam logic [T8_W-1:0] T8_ZERO = {T8_W{1'b0}};

  initial begin
    if (T16_W < 2 || T16_W > DW) begin
      $error("peripheral_event_flags_low: T16_W out of range");
    end
    if (T8_W < 1 || T8_W > DW) begin
      $error("peripheral_event_flags_low: T8_W out of range");
    end
  end

  typedef struct packed {
    logic ack;
    logic [DW-1:0] rdata;
    logic [FW-1:0] mask;
    logic [MW-1:0] mode;
    logic [T16_W-1:0] cmp_val;
    logic [T16_W-1:0] cap_val;
    logic [T16_W-1:0] t16_prev;
    logic t8_eq_prev;
    logic cmp_eq_prev;
    logic [FW-1:0] flags_view;
    logic irq;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  logic [FW-1:0] flags;
  logic [FW-1:0] hw_set;
  logic [FW-1:0] sw_set;
  logic [FW-1:0] sw_clr;
  logic [FW-1:0] set_all;
  logic serial_set;
  logic master_set;
  logic idle_set;
  logic ccp_set;
  logic capture_hit;
  logic compare_hit;
  logic t8_eq;
  logic cmp_eq;
  logic period_set;
  logic ovf_set;
  logic bus_req;
  logic wr_commit;
  logic hit_flags;
  logic hit_mask;
  logic hit_mode;
  logic hit_cmp;
  logic hit_force;
  logic hit_cap;
  logic [DW-1:0] rd_word;
  logic [DW-1:0] mask_merged;
  logic [DW-1:0] mode_merged;
  logic [DW-1:0] cmp_merged;

  // Byte-lane merge of write data onto the old word of a register.
  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] old_word,
    input logic [DW-1:0] new_word,
    input logic [event_flags_pkg::SEL_W-1:0] sel
  );
    logic [DW-1:0] res;
    res = old_word;
    for (int b = 0; b < DW; b++) begin
      if (sel[b / event_flags_pkg::LANE_W]) begin
        res[b] = new_word[b];
      end
    end
    return res;
  endfunction : lane_merge

  // Serial module events.
  always_comb begin
    master_set = 1'b0;
    idle_set = 1'b0;
    if (i2c_master_mode_i) begin
      if (i2c_start_done_i) begin
        master_set = 1'b1;
      end
      if (i2c_stop_done_i) begin
        master_set = 1'b1;
      end
      if (i2c_restart_done_i) begin
        master_set = 1'b1;
      end
      if (i2c_ack_done_i) begin
        master_set = 1'b1;
      end
    end
    // Bus conditions from another master only count while idle.
    if (serial_idle_i) begin
      if (bus_start_seen_i) begin
        idle_set = 1'b1;
      end
      if (bus_stop_seen_i) begin
        idle_set = 1'b1;
      end
    end
    serial_set = serial_xfer_done_i | master_set | idle_set;
  end

  // Capture/compare and timer events. Equality is edge detected so a
  // timer that dwells on a value through a prescaler sets a flag once.
  always_comb begin
    t8_eq = (timer8_count_i == timer8_period_i);
    cmp_eq = (timer16_count_i == st_r.cmp_val);
    capture_hit = 1'b0;
    compare_hit = 1'b0;
    case (st_r.mode)
      event_flags_pkg::MODE_CAPTURE: begin
        capture_hit = capture_strobe_i;
      end
      event_flags_pkg::MODE_COMPARE: begin
        compare_hit = cmp_eq & ~st_r.cmp_eq_prev;
      end
      default: begin
        capture_hit = 1'b0;
        compare_hit = 1'b0;
      end
    endcase
    ccp_set = capture_hit | compare_hit;
    period_set = t8_eq & ~st_r.t8_eq_prev;
    ovf_set = (st_r.t16_prev == T16_MAX) &&
              (timer16_count_i == T16_ZERO);
  end

  // Sets ignore the mask and any enable elsewhere.
  always_comb begin
    hw_set = '0;
    hw_set[event_flags_pkg::OVF_BIT] = ovf_set;
    hw_set[event_flags_pkg::PERIOD_BIT] = period_set;
    hw_set[event_flags_pkg::CCP_BIT] = ccp_set;
    hw_set[event_flags_pkg::SERIAL_BIT] = serial_set;
  end

  // Bus decode. A write commits only at the edge on which the master sees
  // ack high, so a request that is withdrawn early never changes state.
  // Clear and force act on byte lane 0 only, since all flags live there.
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i;
    wr_commit = bus_req & st_r.ack & wb_we_i;
    hit_flags = (wb_adr_i == event_flags_pkg::FLAGS_OFS);
    hit_mask = (wb_adr_i == event_flags_pkg::MASK_OFS);
    hit_mode = (wb_adr_i == event_flags_pkg::MODE_OFS);
    hit_cmp = (wb_adr_i == event_flags_pkg::CMP_OFS);
    hit_force = (wb_adr_i == event_flags_pkg::FORCE_OFS);
    hit_cap = (wb_adr_i == event_flags_pkg::CAP_OFS);
    sw_clr = '0;
    sw_set = '0;
    if (wr_commit && hit_flags && wb_sel_i[0]) begin
      sw_clr = wb_dat_i[FW-1:0];
    end
    if (wr_commit && hit_force && wb_sel_i[0]) begin
      sw_set = wb_dat_i[FW-1:0];
    end
    set_all = hw_set | sw_set;
  end

  // Read mux; bits above a register's width and unmapped words read zero.
  always_comb begin
    rd_word = event_flags_pkg::DATA_ZERO;
    if (hit_flags) begin
      rd_word[FW-1:0] = flags;
    end else if (hit_mask) begin
      rd_word[FW-1:0] = st_r.mask;
    end else if (hit_mode) begin
      rd_word[MW-1:0] = st_r.mode;
    end else if (hit_cmp) begin
      rd_word[T16_W-1:0] = st_r.cmp_val;
    end else if (hit_cap) begin
      rd_word[T16_W-1:0] = st_r.cap_val;
    end else begin
      rd_word = event_flags_pkg::DATA_ZERO;
    end
  end

  always_comb begin
    mask_merged = event_flags_pkg::DATA_ZERO;
    mode_merged = event_flags_pkg::DATA_ZERO;
    cmp_merged = event_flags_pkg::DATA_ZERO;
    mask_merged[FW-1:0] = st_r.mask;
    mode_merged[MW-1:0] = st_r.mode;
    cmp_merged[T16_W-1:0] = st_r.cmp_val;
    mask_merged = lane_merge(mask_merged, wb_dat_i, wb_sel_i);
    mode_merged = lane_merge(mode_merged, wb_dat_i, wb_sel_i);
    cmp_merged = lane_merge(cmp_merged, wb_dat_i, wb_sel_i);
  end

  // Next state of the bus slave, the configuration registers and the edge
  // detectors. Read data is captured when the request is first seen and
  // stands for the ack cycle; it returns to zero once the bus is idle.
  // The interrupt and the flag view are registered so that every output
  // comes straight from a flip-flop, one cycle behind the flag bits.
  always_comb begin
    st_nxt = st_r;
    // Ack one cycle after the request, dropped in the following cycle.
    st_nxt.ack = bus_req & ~st_r.ack;
    if (bus_req && !st_r.ack) begin
      st_nxt.rdata = rd_word;
    end else if (!bus_req) begin
      st_nxt.rdata = event_flags_pkg::DATA_ZERO;
    end
    if (wr_commit && hit_mask) begin
      st_nxt.mask = mask_merged[FW-1:0];
    end
    if (wr_commit && hit_mode) begin
      st_nxt.mode = mode_merged[MW-1:0];
    end
    if (wr_commit && hit_cmp) begin
      st_nxt.cmp_val = cmp_merged[T16_W-1:0];
    end
    if (capture_hit) begin
      st_nxt.cap_val = timer16_count_i;
    end
    st_nxt.t16_prev = timer16_count_i;
    st_nxt.t8_eq_prev = t8_eq;
    st_nxt.cmp_eq_prev = cmp_eq;
    st_nxt.flags_view = flags;
    st_nxt.irq = |(flags & st_r.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.ack <= 1'b0;
      st_r.rdata <= event_flags_pkg::DATA_ZERO;
      st_r.mask <= event_flags_pkg::MASK_RST;
      st_r.mode <= event_flags_pkg::MODE_RST;
      st_r.cmp_val <= T16_ZERO;
      st_r.cap_val <= T16_ZERO;
      st_r.t16_prev <= T16_ZERO;
      st_r.t8_eq_prev <= 1'b0;
      st_r.cmp_eq_prev <= 1'b0;
      st_r.flags_view <= event_flags_pkg::FLAGS_RST;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  sticky_flag_bank #(
    .WIDTH(FW)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(set_all),
    .clr_i(sw_clr),
    .flags_o(flags)
  );

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;
  assign flags_o = st_r.flags_view;
  assign irq_o = st_r.irq;

endmodule : peripheral_event_flags_low

/* File: test/event_flags_properties.sv */
// Checker for the event flag block: flag setting, clearing and bus reads.
// Assumes one clock domain; bound to peripheral_event_flags_low by the bind below.
`timescale 1ns/100ps
module event_flags_properties #(
  parameter int T16_W = 16,
  parameter int T8_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [event_flags_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [event_flags_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [event_flags_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [event_flags_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_xfer_done_i,
  input wire logic i2c_master_mode_i,
  input wire logic i2c_start_done_i,
  input wire logic i2c_ack_done_i,
  input wire logic serial_idle_i,
  input wire logic bus_start_seen_i,
  input wire logic [T16_W-1:0] timer16_count_i,
  input wire logic [T8_W-1:0] timer8_count_i,
  input wire logic [T8_W-1:0] timer8_period_i,
  input wire logic [event_flags_pkg::FLAG_W-1:0] flags_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_flags = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
  wire logic wr_flags = wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];

  serial_done_a: assert property (serial_xfer_done_i |-> ##2 flags_o[3])
    else $error("serial flag not set");
  start_done_a: assert property (i2c_master_mode_i && i2c_start_done_i
    |-> ##2 flags_o[3]) else $error("start flag not set");
  ack_done_a: assert property (i2c_master_mode_i && i2c_ack_done_i
    |-> ##2 flags_o[3]) else $error("ack flag not set");
  idle_start_a: assert property (serial_idle_i && bus_start_seen_i
    |-> ##2 flags_o[3]) else $error("idle start flag not set");
  period_match_a: assert property (!$past(rst_i) &&
    $rose(timer8_count_i == timer8_period_i) |-> ##2 flags_o[1])
    else $error("period flag not set");
  overflow_a: assert property (!$past(rst_i) && &$past(timer16_count_i)
    && timer16_count_i == '0 |-> ##2 flags_o[0])
    else $error("overflow flag not set");
  flag_clear_a: assert property (!$past(rst_i) &&
    |($past(flags_o) & ~flags_o) |-> $past(wr_flags, 2) &&
    (($past(flags_o) & ~flags_o & ~$past(wb_dat_i[3:0], 2)) == '0))
    else $error("flag dropped without a clear");
  unused_zero_a: assert property (rd_flags |-> wb_dat_o[31:4] == '0)
    else $error("unused flag bits not zero");
  reset_clear_a: assert property ($fell(rst_i) |-> flags_o == '0 && !irq_o)
    else $error("flags not clear after reset");

  cover property (wr_flags);
  cover property ($rose(irq_o));
  cover property ($rose(flags_o[2]));
endmodule : event_flags_properties

bind peripheral_event_flags_low event_flags_properties #(
  .T16_W(T16_W), .T8_W(T8_W)) checks (.clk_i, .rst_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_xfer_done_i,
  .i2c_master_mode_i, .i2c_start_done_i, .i2c_ack_done_i, .serial_idle_i,
  .bus_start_seen_i, .timer16_count_i, .timer8_count_i, .timer8_period_i,
  .flags_o, .irq_o);

/* File: test/peripheral_event_flags_low_tb_top.sv */
// Self-checking bench for the event flag block through its Wishbone port.
// Assumes the checker file is compiled before it and binds itself.
`timescale 1ns/100ps
module peripheral_event_flags_low_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [7:0] ev = 8'h00;
  logic [15:0] t16 = 16'h0000;
  logic [7:0] t8 = 8'h00;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] flags_o;
  logic irq_o;
  logic [31:0] q;
  int n_fail = 0;
  int compares = 0;

  peripheral_event_flags_low DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_xfer_done_i(ev[0]),
    .i2c_master_mode_i(1'b1), .i2c_start_done_i(ev[1]),
    .i2c_stop_done_i(ev[2]), .i2c_restart_done_i(ev[3]),
    .i2c_ack_done_i(ev[4]), .serial_idle_i(1'b1), .bus_start_seen_i(ev[5]),
    .bus_stop_seen_i(ev[6]), .capture_strobe_i(ev[7]),
    .timer16_count_i(t16), .timer8_count_i(t8), .timer8_period_i(8'h10),
    .flags_o(flags_o), .irq_o(irq_o));

  always #5 clk_i = ~clk_i;

  task automatic chk(input string s, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    q = wb_dat_o;
    chk("ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdchk(input string s, input logic [7:0] a,
                       input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(s, q, e);
  endtask : rdchk

  task automatic hit(input int k);
    ev <= 8'h01 << k;
    @(posedge clk_i);
    ev <= 8'h00;
    repeat (2) @(posedge clk_i);
  endtask : hit

  task automatic roll;
    t16 <= 16'hFFFF;
    @(posedge clk_i);
    t16 <= 16'h0000;
    repeat (3) @(posedge clk_i);
  endtask : roll

  task automatic reset_state;
    chk("flags_o", {28'h0, flags_o}, 32'h0);
    rdchk("flags", 8'h00, 32'h0);
    rdchk("mask", 8'h04, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
  endtask : reset_state

  task automatic serial_events;
    for (int k = 0; k < 7; k++) begin
      hit(k);
      repeat (4) @(posedge clk_i);
      rdchk("serial", 8'h00, 32'h8);
      wb(1'b1, 8'h00, 32'h8);
      rdchk("cleared", 8'h00, 32'h0);
    end
  endtask : serial_events

  task automatic timer_events;
    roll;
    chk("overflow", {28'h0, flags_o}, 32'h1);
    t8 <= 8'h10;
    repeat (3) @(posedge clk_i);
    chk("period", {28'h0, flags_o}, 32'h3);
    wb(1'b1, 8'h00, 32'h3);
    t16 <= 16'h00A5;
    wb(1'b1, 8'h08, 32'h1);
    hit(7);
    rdchk("capture", 8'h00, 32'h4);
    rdchk("captured", 8'h14, 32'hA5);
    wb(1'b1, 8'h00, 32'h4);
    wb(1'b1, 8'h0C, 32'h0100);
    wb(1'b1, 8'h08, 32'h2);
    t16 <= 16'h0100;
    repeat (3) @(posedge clk_i);
    rdchk("compare", 8'h00, 32'h4);
    wb(1'b1, 8'h00, 32'h4);
    wb(1'b1, 8'h08, 32'h3);
    hit(7);
    rdchk("pwm_strobe", 8'h00, 32'h0);
    rdchk("cap_held", 8'h14, 32'hA5);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h10, 32'h2);
    rdchk("forced", 8'h00, 32'h2);
    rdchk("force_rd", 8'h10, 32'h0);
    wb(1'b1, 8'h00, 32'hF);
  endtask : timer_events

  task automatic irq_path;
    wb(1'b1, 8'h04, 32'h1);
    roll;
    chk("irq_on", {31'h0, irq_o}, 32'h1);
    wb(1'b1, 8'h04, 32'h0);
    @(posedge clk_i);
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    rdchk("still_set", 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h1);
    @(posedge clk_i);
    chk("irq_again", {31'h0, irq_o}, 32'h1);
    wb(1'b1, 8'h00, 32'h1);
    @(posedge clk_i);
    chk("irq_off", {31'h0, irq_o}, 32'h0);
  endtask : irq_path

  // A clear write commits at the same edge as a fresh serial event.
  task automatic set_wins;
    hit(0);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b1;
    wb_adr_i <= 8'h00;
    wb_dat_i <= 32'h8;
    wait (wb_ack_o === 1'b1);
    ev <= 8'h01;
    @(posedge clk_i);
    chk("ack", {31'h0, wb_ack_o}, 32'h1);
    ev <= 8'h00;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("set_wins", {28'h0, flags_o}, 32'h8);
  endtask : set_wins

  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    reset_state;
    serial_events;
    timer_events;
    irq_path;
    set_wins;
    complete_run;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    complete_run;
  end
endmodule : peripheral_event_flags_low_tb_top
